/* File: pmsed_cfg.svh */
// Purpose: Constants of the peripheral memory SECDED wrapper.
// Assumes: Included by its bare name from the design files.
// Notes: Definitions only.
`ifndef PMSED_CFG_SVH
`define PMSED_CFG_SVH

// ------------------------------------------------------------
// Reset values and fixed figures
// ------------------------------------------------------------
`define PMSED_STS_RST 1'h0
`define PMSED_INJ_MAX 3
`define PMSED_RD_LAT 2

`endif

/* File: pmsed_pkg.sv */
// Purpose: Types shared by the SECDED wrapper and its codec.
// Assumes: Nothing beyond the constant header.
// Notes: The check width follows the Hamming bound plus one overall parity bit.
package pmsed_pkg;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PMSED_OK = 2'b00,
		PMSED_SEC = 2'b01,
		PMSED_DED = 2'b10
	} pmsed_kind_e;

	typedef enum logic {
		PMSED_PATH_TX = 1'b0,
		PMSED_PATH_BUS = 1'b1
	} pmsed_path_e;

	// Smallest Hamming width covering the data, plus the overall parity bit.
	function automatic int pmsed_chk_w(input int dw);
		int r;
		r = 1;
		while ((1 << r) < dw + r + 1) begin
			r = r + 1;
		end
		return r + 1;
	endfunction

endpackage

/* File: pmsed_codec.sv */
// Purpose: Combinational SECDED encoder and checker.
// Assumes: CW equals pmsed_chk_w(DW); the top bit of the check field is overall parity.
// Notes: Data bits take the non power-of-two Hamming positions in ascending order.
`timescale 1ns/1ns
module pmsed_codec #(
	parameter int DW = 32,
	parameter int CW = 7
) (
	input wire logic [DW-1:0] enc_data,
	output logic [CW-1:0] enc_chk,
	input wire logic [DW+CW-1:0] dec_word,
	output logic [DW-1:0] dec_data,
	output pmsed_pkg::pmsed_kind_e dec_kind
);
	import pmsed_pkg::*;

	localparam int HW = CW - 1;

	// Hamming position of data bit i.
	function automatic logic [HW-1:0] dpos(input int i);
		int p;
		int k;
		logic [HW-1:0] r;
		r = '0;
		k = -1;
		for (p = 3; p < DW + CW + 1; p++) begin
			if ((p & (p - 1)) != 0) begin
				k = k + 1;
				if (k == i) begin
					r = HW'(p);
				end
			end
		end
		return r;
	endfunction

	// Hamming check bits of a data word.
	function automatic logic [HW-1:0] hamm(input logic [DW-1:0] d);
		logic [HW-1:0] h;
		h = '0;
		for (int i = 0; i < DW; i++) begin
			if (d[i]) begin
				h = h ^ dpos(i);
			end
		end
		return h;
	endfunction

	// ------------------------------------------------------------
	// Encode and check
	// ------------------------------------------------------------
	wire logic [HW-1:0] enc_h = hamm(enc_data);
	wire logic [DW-1:0] rd_d = dec_word[DW-1:0];
	wire logic [HW-1:0] syn = hamm(rd_d) ^ dec_word[DW+HW-1:DW];
	wire logic ovr = ^dec_word;

	assign enc_chk = {^{enc_data, enc_h}, enc_h};

	// A zero syndrome with odd parity means the parity bit itself flipped.
	assign dec_kind = (!ovr && syn == '0) ? PMSED_OK : (ovr ? PMSED_SEC : PMSED_DED);

	// Only a single error is repaired; a double error leaves the data as read.
	always_comb begin
		for (int i = 0; i < DW; i++) begin
			dec_data[i] = rd_d[i] ^ (ovr && syn == dpos(i));
		end
	end

endmodule

/* File: pmsed_edac.sv */
// Purpose: SECDED protected memory with status, count and error injection controls.
// Assumes: All inputs synchronous to clk_sys; one write and one read port.
// Notes: Reads return data two edges after the request; control bits are plain ports.
`timescale 1ns/1ns
`include "pmsed_cfg.svh"

// Summary of operation
// RULE1: A 32-bit word is stored with seven check bits on every write.
// RULE2: A 64-bit word is stored with eight check bits on every write.
// RULE3: Reads check the word, repair single errors and flag double errors.
// RULE4: A double error delivers the stored data unrepaired.
// RULE5: A bus read of a double error returns an error response, data marked corrupt.
// RULE6: A bus read double error raises the interrupt only when its enable is set.
// RULE7: A transmit read passes corrupt data on and raises the interrupt.
// RULE8: Each instance owns its status, enables, error count and injection controls.
// RULE9: Software can flip one, two or three written data bits.
// RULE10: The error count rises once per error event and saturates.
// RULE11: Single and double error flags stay set until software clears them.
module pmsed_edac #(
	parameter int DW = 32,
	parameter int AW = 8,
	parameter int CNT_W = 16
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	input wire logic rd_req,
	input wire logic [AW-1:0] rd_addr,
	input wire pmsed_pkg::pmsed_path_e rd_path,
	output logic rd_valid,
	output logic [DW-1:0] rd_data,
	output logic rd_err_resp,
	output logic rd_corrupt,
	input wire logic ie_sec,
	input wire logic ie_ded,
	input wire logic clr_sec,
	input wire logic clr_ded,
	output logic sts_sec,
	output logic sts_ded,
	output logic sts_ded_tx,
	output logic [CNT_W-1:0] err_cnt,
	input wire logic cnt_clr,
	input wire logic inj_en,
	input wire logic [1:0] inj_cnt,
	input wire logic [$clog2(DW)-1:0] inj_pos,
	output logic irq
);
	import pmsed_pkg::*;

	localparam int CW = pmsed_chk_w(DW);
	localparam int WW = DW + CW;
	localparam logic [CNT_W-1:0] CNT_MAX = '1;

	// Flip mask of up to three adjacent bits, wrapping around the word.
	function automatic logic [DW-1:0] inj_mask(input logic [1:0] n, input int pos);
		logic [DW-1:0] m;
		m = '0;
		for (int k = 0; k < `PMSED_INJ_MAX; k++) begin
			if (k < int'(n)) begin
				m[(pos + k) % DW] = 1'h1;
			end
		end
		return m;
	endfunction

	// ------------------------------------------------------------
	// Storage and codec
	// ------------------------------------------------------------
	logic [WW-1:0] mem [0:(1<<AW)-1];
	logic [WW-1:0] rdw_ff;
	logic vld1_ff;
	pmsed_path_e path1_ff;
	wire logic [CW-1:0] enc_chk;
	wire logic [DW-1:0] fix_data;
	pmsed_kind_e kind;

	pmsed_codec #(.DW(DW), .CW(CW)) u_codec (
		.enc_data(wr_data),
		.enc_chk(enc_chk),
		.dec_word(rdw_ff),
		.dec_data(fix_data),
		.dec_kind(kind)
	);

	// Check bits come from the clean data, so injected flips look like real faults.
	wire logic [DW-1:0] wr_flip = inj_en ? inj_mask(inj_cnt, int'(inj_pos)) : '0; // RULE9
	wire logic [WW-1:0] wr_word = {enc_chk, wr_data ^ wr_flip}; // RULE1 RULE2

	// Write port; a read of the same address in the same cycle sees the old word.
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_word; // RULE1 RULE2
		end
	end

	// ------------------------------------------------------------
	// Read pipeline
	// ------------------------------------------------------------
	// The array has no reset; only the valid flag and the path are reset.
	always_ff @(posedge clk_sys) begin
		rdw_ff <= mem[rd_addr];
		if (!resetn) begin
			vld1_ff <= 1'h0;
			path1_ff <= PMSED_PATH_TX;
		end else begin
			vld1_ff <= rd_req;
			path1_ff <= rd_path;
		end
	end

	// Error events of the word now in the check stage.
	wire logic ev_sec = vld1_ff && kind == PMSED_SEC; // RULE3
	wire logic ev_ded = vld1_ff && kind == PMSED_DED; // RULE3
	wire logic ev_bus = ev_ded && path1_ff == PMSED_PATH_BUS; // RULE5
	wire logic ev_tx = ev_ded && path1_ff == PMSED_PATH_TX; // RULE7

	// The codec repairs only single errors, so a double error goes out as stored.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rd_valid <= 1'h0;
			rd_data <= '0;
			rd_err_resp <= 1'h0;
			rd_corrupt <= 1'h0;
		end else begin
			rd_valid <= vld1_ff;
			rd_data <= vld1_ff ? fix_data : rd_data; // RULE3 RULE4 RULE7
			rd_err_resp <= ev_bus; // RULE5
			rd_corrupt <= ev_ded; // RULE5
		end
	end

	// ------------------------------------------------------------
	// Status, count and interrupt
	// ------------------------------------------------------------
	// A new event in the cycle of a clear keeps the flag set.
	wire logic nxt_sec = ev_sec || (sts_sec && !clr_sec); // RULE11
	wire logic nxt_ded = ev_ded || (sts_ded && !clr_ded); // RULE11
	wire logic nxt_tx = ev_tx || (sts_ded_tx && !clr_ded); // RULE7
	wire logic cnt_up = (ev_sec || ev_ded) && err_cnt != CNT_MAX; // RULE10

	// Saturation keeps software from missing a burst that would wrap to zero.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			sts_sec <= `PMSED_STS_RST;
			sts_ded <= `PMSED_STS_RST;
			sts_ded_tx <= `PMSED_STS_RST;
			err_cnt <= '0;
		end else begin
			sts_sec <= nxt_sec; // RULE8
			sts_ded <= nxt_ded; // RULE8
			sts_ded_tx <= nxt_tx;
			err_cnt <= cnt_clr ? '0 : err_cnt + CNT_W'(cnt_up); // RULE8 RULE10
		end
	end

	// Transmit-path double errors interrupt regardless of the enables.
	assign irq = (sts_sec && ie_sec) || (sts_ded && ie_ded) || sts_ded_tx; // RULE6 RULE7

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	wr_store_a: assert property ( // RULE1 RULE2
		wr_en && !inj_en |=> mem[$past(wr_addr)] == {$past(enc_chk), $past(wr_data)})
		else $error("Stored word does not carry the encoded check bits.");
	chk_width_a: assert property ( // RULE1 RULE2
		1'h1 |-> CW == ((DW == 64) ? 8 : 7))
		else $error("Check field width is wrong for the data width.");
	inj_flip_a: assert property ( // RULE9
		wr_en && inj_en |=> $countones(mem[$past(wr_addr)][DW-1:0] ^ $past(wr_data))
			== int'($past(inj_cnt)))
		else $error("Injected flip count differs from the request.");
	ded_keep_a: assert property ( // RULE4
		ev_ded |=> rd_data == $past(rdw_ff[DW-1:0]) && rd_corrupt)
		else $error("Double error data was altered.");
	sec_fix_a: assert property ( // RULE3
		ev_sec |=> $countones(rd_data ^ $past(rdw_ff[DW-1:0])) <= 1 && !rd_corrupt)
		else $error("Single error repair changed more than one bit.");
	bus_err_a: assert property ( // RULE5
		rd_err_resp |-> rd_valid && rd_corrupt && $past(path1_ff) == PMSED_PATH_BUS)
		else $error("Error response without a bus double error.");
	tx_pass_a: assert property ( // RULE7
		ev_tx |=> rd_valid && !rd_err_resp && sts_ded_tx && irq)
		else $error("Transmit double error not passed on with interrupt.");
	irq_gate_a: assert property ( // RULE6
		irq && !sts_ded_tx && !(sts_sec && ie_sec) |-> sts_ded && ie_ded)
		else $error("Interrupt raised with its enable clear.");
	cnt_step_a: assert property ( // RULE10
		(ev_sec || ev_ded) && !cnt_clr && err_cnt != CNT_MAX |=> err_cnt == $past(err_cnt) + 1'h1)
		else $error("Error count did not step once.");
	cnt_sat_a: assert property ( // RULE10
		err_cnt == CNT_MAX && !cnt_clr |=> err_cnt == CNT_MAX)
		else $error("Error count wrapped.");
	sticky_a: assert property ( // RULE11
		sts_ded && !clr_ded |=> sts_ded [*1])
		else $error("Double error flag dropped without a clear.");
	set_wins_a: assert property ( // RULE11
		ev_sec && clr_sec |=> sts_sec)
		else $error("Clear beat a simultaneous single error event.");

	sec_seen_c: cover property (ev_sec ##1 rd_valid);
	bus_ded_c: cover property (ev_bus ##1 rd_err_resp);
	tx_ded_c: cover property (ev_tx ##1 irq);
	cnt_full_c: cover property (err_cnt == CNT_MAX);

endmodule

/* File: pmsed_reader.sv */
// Purpose: Far-side reader model, a bus master or transmit datapath pulling words.
// Assumes: Inputs sampled one nanosecond after the rising edge of clk_sys.
// Notes: The address is inverted once released so a stale value never looks valid.
`timescale 1ns/1ns
module pmsed_reader (
	input wire logic clk_sys,
	output logic rd_req,
	output logic [7:0] rd_addr,
	output pmsed_pkg::pmsed_path_e rd_path,
	input wire logic rd_valid,
	input wire logic [31:0] rd_data,
	input wire logic rd_err_resp,
	input wire logic rd_corrupt
);
	import pmsed_pkg::*;
	logic [31:0] got_data;
	logic got_resp;
	logic got_bad;
	int got_lat;
	// ------------------------------------------------------------
	// Read transfer
	// ------------------------------------------------------------
	// Every output is driven at time zero, so the request starts idle.
	initial begin
		rd_req = 1'b0;
		rd_addr = 8'h00;
		rd_path = PMSED_PATH_BUS;
	end
	// One pulse per word; gap idles first to act as a slow consumer.
	task automatic read(input logic [7:0] a, input pmsed_path_e p, input int gap);
		// Callers return one nanosecond after an edge, so idle edges keep that offset.
		repeat (gap) begin
			@(posedge clk_sys);
			#1;
		end
		rd_req = 1'b1;
		rd_addr = a;
		rd_path = p;
		@(posedge clk_sys);
		#1;
		rd_req = 1'b0;
		rd_addr = ~a;
		got_lat = 1; // The taking edge counts as the first edge of the latency.
		while (rd_valid !== 1'b1 && got_lat < 8) begin
			@(posedge clk_sys);
			#1;
			got_lat++;
		end
		got_data = rd_data;
		got_resp = rd_err_resp;
		got_bad = rd_corrupt;
	endtask
endmodule

/* File: test_pmsed_edac.sv */
// Purpose: Self-checking bench of the SECDED wrapper with a 32-bit word.
// Assumes: Tasks start and end one nanosecond after a rising edge.
// Notes: A 3-bit counter lets saturation be reached in a few reads.
`timescale 1ns/1ns
`include "pmsed_cfg.svh"
module test_pmsed_edac;
	import pmsed_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic wr_en = 1'b0;
	logic [7:0] wr_addr = 8'h00;
	logic [31:0] wr_data = 32'h0;
	logic ie_sec = 1'b0;
	logic ie_ded = 1'b0;
	logic clr_sec = 1'b0;
	logic clr_ded = 1'b0;
	logic cnt_clr = 1'b0;
	logic inj_en = 1'b0;
	logic [1:0] inj_cnt = 2'h0;
	logic [4:0] inj_pos = 5'h1F;
	logic rd_req;
	logic [7:0] rd_addr;
	pmsed_path_e rd_path;
	logic rd_valid, rd_err_resp, rd_corrupt, sts_sec, sts_ded, sts_ded_tx, irq;
	logic [31:0] rd_data;
	logic [2:0] err_cnt;
	int fails = 0;
	int tests_run = 0;
	int cyc = 0;
	// ------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------
	pmsed_edac #(.DW(32), .AW(8), .CNT_W(3)) u_pmsed_edac (.clk_sys(clk_sys),
		.resetn(resetn), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_req(rd_req), .rd_addr(rd_addr), .rd_path(rd_path), .rd_valid(rd_valid),
		.rd_data(rd_data), .rd_err_resp(rd_err_resp), .rd_corrupt(rd_corrupt),
		.ie_sec(ie_sec), .ie_ded(ie_ded), .clr_sec(clr_sec), .clr_ded(clr_ded),
		.sts_sec(sts_sec), .sts_ded(sts_ded), .sts_ded_tx(sts_ded_tx), .err_cnt(err_cnt),
		.cnt_clr(cnt_clr), .inj_en(inj_en), .inj_cnt(inj_cnt), .inj_pos(inj_pos), .irq(irq));
	pmsed_reader u_pmsed_reader (.clk_sys(clk_sys), .rd_req(rd_req), .rd_addr(rd_addr),
		.rd_path(rd_path), .rd_valid(rd_valid), .rd_data(rd_data),
		.rd_err_resp(rd_err_resp), .rd_corrupt(rd_corrupt));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	always #2 clk_sys = ~clk_sys;
	// A hang would otherwise stall the run; the run needs well under this many cycles.
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			summarize();
		end
	end
	task automatic summarize();
		if (fails == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Writes one word; n data bits are flipped when n is not zero.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] n);
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = d;
		inj_cnt = n;
		inj_en = (n != 2'h0);
		@(posedge clk_sys);
		#1;
		wr_en = 1'b0;
		inj_en = 1'b0;
	endtask
	task automatic clr(input logic s, input logic d, input logic c);
		clr_sec = s;
		clr_ded = d;
		cnt_clr = c;
		@(posedge clk_sys);
		#1;
		{clr_sec, clr_ded, cnt_clr} = 3'h0;
	endtask
	task automatic rd(input logic [7:0] a, input pmsed_path_e p, input int gap);
		u_pmsed_reader.read(a, p, gap);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_clean_and_single();
		wr(8'h10, 32'hA5A50F0F, 2'h0);
		rd(8'h10, PMSED_PATH_BUS, 0);
		check(u_pmsed_reader.got_data, 32'hA5A50F0F);
		check(u_pmsed_reader.got_lat, `PMSED_RD_LAT);
		check({u_pmsed_reader.got_resp, u_pmsed_reader.got_bad, err_cnt}, 5'h00);
		wr(8'h11, 32'h12345678, 2'h1);
		rd(8'h11, PMSED_PATH_BUS, 2);
		check(u_pmsed_reader.got_data, 32'h12345678);
		check({sts_sec, sts_ded, err_cnt, irq}, 6'h22);
		ie_sec = 1'b1;
		@(posedge clk_sys);
		#1;
		check(irq, 1'b1);
		clr(1'b1, 1'b0, 1'b0);
		check({sts_sec, irq}, 2'h0);
	endtask
	// Two flips at the top bit wrap round to bit zero.
	task automatic t_double();
		wr(8'h12, 32'h000000F0, 2'h2);
		rd(8'h12, PMSED_PATH_BUS, 0);
		check(u_pmsed_reader.got_data, 32'h800000F1);
		check({u_pmsed_reader.got_resp, u_pmsed_reader.got_bad}, 2'h3);
		check({sts_ded, sts_ded_tx, irq, err_cnt}, 6'h22);
		ie_ded = 1'b1;
		@(posedge clk_sys);
		#1;
		check(irq, 1'b1);
		clr(1'b0, 1'b1, 1'b0);
		ie_ded = 1'b0;
		rd(8'h12, PMSED_PATH_TX, 1);
		check({u_pmsed_reader.got_resp, u_pmsed_reader.got_bad}, 2'h1);
		check(u_pmsed_reader.got_data, 32'h800000F1);
		check({sts_ded_tx, irq, err_cnt}, 5'h1B);
		clr(1'b0, 1'b1, 1'b0);
		check({sts_ded, sts_ded_tx, irq}, 3'h0);
	endtask
	task automatic t_count();
		int i;
		for (i = 0; i < 6; i++) rd(8'h12, PMSED_PATH_BUS, i % 2);
		check(err_cnt, 3'h7);
		clr(1'b0, 1'b1, 1'b1);
		rd(8'h10, PMSED_PATH_BUS, 0);
		check(err_cnt, 3'h0);
		wr(8'h13, 32'hFFFF0000, 2'h3);
		rd(8'h13, PMSED_PATH_BUS, 0);
		check(err_cnt, 3'h1);
		// A clear that meets a new single error in the same edge must lose.
		clr(1'b1, 1'b0, 1'b1);
		fork
			rd(8'h11, PMSED_PATH_BUS, 0);
			begin
				@(posedge clk_sys);
				#1;
				clr(1'b1, 1'b0, 1'b0);
			end
		join
		check({sts_sec, err_cnt}, 4'h9);
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		#1;
		check({rd_valid, sts_sec, sts_ded, sts_ded_tx, irq, err_cnt}, 8'h00);
		resetn = 1'b1;
		t_clean_and_single();
		t_double();
		t_count();
		summarize();
	end
endmodule
